/* include/cmyc_pkg.sv */
// constants and helpers shared by the month and year calendar counters
package cmyc_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses, one aligned word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_MONTH = 8'h00;
	localparam logic [7:0] ADDR_YEAR = 8'h04;
	localparam logic [7:0] ADDR_CTRL = 8'h08;
	localparam logic [7:0] ADDR_STAT = 8'h0c;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_CNT_EN_BIT = 0;
	localparam int STAT_MON_PEND_BIT = 0;
	localparam int STAT_YEAR_PEND_BIT = 1;
	localparam int STAT_LEAP_BIT = 2;
	localparam logic [7:0] CTRL_RESET = 8'h01;
	localparam logic [7:0] MONTH_RESET = 8'h01;
	localparam logic [7:0] YEAR_RESET = 8'h00;

	// ----------------------------------------------------------------
	// counting ranges in bcd
	// ----------------------------------------------------------------
	localparam logic [7:0] MONTH_MIN = 8'h01;
	localparam logic [7:0] MONTH_MAX = 8'h12;
	localparam logic [7:0] YEAR_MIN = 8'h00;
	localparam logic [7:0] YEAR_MAX = 8'h99;

	// ----------------------------------------------------------------
	// timing: calendar count clock derived from the 250 mhz bus clock
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int RTC_PERIOD_NS = 30518;
	localparam int RTC_DIV_CYC = RTC_PERIOD_NS / CLK_PERIOD_NS;
	localparam int XFER_MAX_TICKS = 2;

	// leap year: tens even and ones 0/4/8, or tens odd and ones 2/6
	function automatic logic cmyc_is_leap(input logic [7:0] y);
		logic [3:0] ones;
		ones = y[3:0];
		if (y[4] == 1'b0) begin
			cmyc_is_leap = (ones == 4'h0) || (ones == 4'h4) || (ones == 4'h8);
		end else begin
			cmyc_is_leap = (ones == 4'h2) || (ones == 4'h6);
		end
	endfunction

	// one decoder for read and write paths
	function automatic logic [3:0] cmyc_decode(input logic [7:0] a);
		cmyc_decode = 4'h0;
		unique case (a)
			ADDR_MONTH: cmyc_decode = 4'h1;
			ADDR_YEAR: cmyc_decode = 4'h2;
			ADDR_CTRL: cmyc_decode = 4'h4;
			ADDR_STAT: cmyc_decode = 4'h8;
			default: cmyc_decode = 4'h0;
		endcase
	endfunction

endpackage

/* hdl/cmyc_tick_div.sv */
// divider that makes the one-cycle calendar count clock enable
`timescale 1ns/10ps
module cmyc_tick_div
	import cmyc_pkg::*;
#(
	parameter int DIV = RTC_DIV_CYC
) (
	input wire logic clk, // bus clock
	input wire logic rstn, // async reset, active low
	output logic tick_r // one-cycle calendar tick
);

	logic [15:0] cnt_r;
	localparam logic [15:0] LAST = 16'(DIV - 1);

	// ----------------------------------------------------------------
	// free-running count, tick on the last value
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= 16'h0000;
			tick_r <= 1'b0;
		end else begin
			tick_r <= (cnt_r == LAST);
			cnt_r <= (cnt_r == LAST) ? 16'h0000 : cnt_r + 16'h0001;
		end
	end

	// two ticks are never adjacent unless the divide is one
	a_tick_spacing: assert property (@(posedge clk) disable iff (!rstn)
		(tick_r && DIV > 1) |=> !tick_r)
		else $error("calendar tick lasted more than one cycle");

endmodule

/* hdl/cmyc_bcd_stage.sv */
// one bcd calendar stage: buffered load, carry count and wrap
`timescale 1ns/10ps
module cmyc_bcd_stage
	import cmyc_pkg::*;
#(
	parameter logic [7:0] MIN_V = 8'h00,
	parameter logic [7:0] MAX_V = 8'h99,
	parameter logic [7:0] RST_V = 8'h00
) (
	input wire logic clk, // bus clock
	input wire logic rstn, // async reset, active low
	input wire logic tick, // calendar count enable
	input wire logic carry_in, // carry from the lower stage
	input wire logic load, // buffered write waiting
	input wire logic [7:0] load_val, // buffered write value
	output logic [7:0] count_r, // current bcd count
	output logic carry_out // overflow toward next stage
);

	logic [7:0] inc_nxt;

	// ----------------------------------------------------------------
	// bcd increment; anything at or past the top wraps to the bottom
	// ----------------------------------------------------------------
	always_comb begin
		if (count_r >= MAX_V) begin
			inc_nxt = MIN_V;
		end else if (count_r[3:0] >= 4'h9) begin
			inc_nxt = {count_r[7:4] + 4'h1, 4'h0};
		end else begin
			inc_nxt = {count_r[7:4], count_r[3:0] + 4'h1};
		end
	end

	// a carry swallowed by a load never ripples further up
	assign carry_out = tick && carry_in && !load && (count_r == MAX_V);

	// load beats carry, so software sees exactly what it wrote
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count_r <= RST_V;
		end else if (tick && load) begin
			count_r <= load_val;
		end else if (tick && carry_in) begin
			count_r <= inc_nxt;
		end
	end

	a_write_wins: assert property (@(posedge clk) disable iff (!rstn)
		(tick && load) |=> (count_r == $past(load_val)))
		else $error("buffered write did not land as written");

	a_wrap_min: assert property (@(posedge clk) disable iff (!rstn)
		carry_out |=> (count_r == MIN_V) && !carry_out)
		else $error("stage overflow did not wrap to its minimum");

endmodule

/* hdl/cmyc_top.sv */
// month and year calendar counters with an apb register slave
`timescale 1ns/10ps
module cmyc_top
	import cmyc_pkg::*;
#(
	parameter int RTC_DIV = RTC_DIV_CYC
) (
	input wire logic pclk, // bus and counter clock
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction, high writes
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic day_carry, // day stage overflow, seen at tick
	output logic [7:0] month_count, // current month, bcd
	output logic [7:0] year_count, // current year, bcd
	output logic leap_year, // current year is a leap year
	output logic year_wrap // pulse when year rolls 99 to 00
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic tick;
	logic mon_carry;
	logic yr_carry;
	logic [7:0] mon_q;
	logic [7:0] yr_q;

	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;
	logic leap_r;
	logic year_wrap_r;

	logic [7:0] ctrl_r;
	logic [7:0] mon_buf_r;
	logic [7:0] yr_buf_r;
	logic mon_pend_r;
	logic yr_pend_r;
	logic mon_pend_nxt;
	logic yr_pend_nxt;

	logic setup_ph;
	logic wr_acc;
	logic [3:0] sel_setup;
	logic [3:0] sel_acc;
	logic [31:0] rd_nxt;
	logic cnt_en;

	// helpers read only by the checks below
	logic [1:0] mon_wait_r;
	logic [1:0] yr_wait_r;
	logic rst_seen_r;

	// ----------------------------------------------------------------
	// calendar count clock
	// ----------------------------------------------------------------
	// single clock domain: the slow count clock is a tick enable
	cmyc_tick_div #(
		.DIV(RTC_DIV)
	) u_div (
		.clk(pclk),
		.rstn(presetn),
		.tick_r(tick)
	);

	// ----------------------------------------------------------------
	// apb phase decode
	// ----------------------------------------------------------------
	assign setup_ph = psel && !penable;
	assign wr_acc = psel && penable && pready_r && pwrite;
	assign sel_setup = cmyc_decode(paddr);
	assign sel_acc = cmyc_decode(paddr);
	assign cnt_en = ctrl_r[CTRL_CNT_EN_BIT];

	// ready rises for the access phase only, so every transfer has
	// exactly one access cycle and the slave never stalls the bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
		end else begin
			pready_r <= setup_ph;
		end
	end

	// error is decided in the setup phase and stands through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_r <= 1'b0;
		end else begin
			pslverr_r <= setup_ph && (sel_setup == 4'h0);
		end
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	// narrow values sit low and the upper bits read as zero
	always_comb begin
		rd_nxt = 32'h0000_0000;
		unique case (1'b1)
			sel_setup[0]: rd_nxt = {24'h00_0000, mon_q};
			sel_setup[1]: rd_nxt = {24'h00_0000, yr_q};
			sel_setup[2]: rd_nxt = {24'h00_0000, ctrl_r};
			sel_setup[3]: begin
				rd_nxt[STAT_MON_PEND_BIT] = mon_pend_r;
				rd_nxt[STAT_YEAR_PEND_BIT] = yr_pend_r;
				rd_nxt[STAT_LEAP_BIT] = leap_r;
			end
			default: rd_nxt = 32'h0000_0000;
		endcase
	end

	// captured at setup so the word is stable for the whole access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (setup_ph && !pwrite) begin
			prdata_r <= rd_nxt;
		end
	end

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	// clearing the enable freezes the carry chain but not the buffers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= CTRL_RESET;
		end else if (wr_acc && sel_acc[2]) begin
			ctrl_r <= {7'h00, pwdata[CTRL_CNT_EN_BIT]};
		end
	end

	// ----------------------------------------------------------------
	// write buffers
	// ----------------------------------------------------------------
	// a write in the same cycle as a tick stays pending: the set
	// wins, and the fresh value lands on the following tick
	always_comb begin
		mon_pend_nxt = mon_pend_r && !tick;
		yr_pend_nxt = yr_pend_r && !tick;
		if (wr_acc && sel_acc[0]) begin
			mon_pend_nxt = 1'b1;
		end
		if (wr_acc && sel_acc[1]) begin
			yr_pend_nxt = 1'b1;
		end
	end

	// buffer values; only the low byte of a write is kept
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mon_buf_r <= MONTH_RESET;
			yr_buf_r <= YEAR_RESET;
		end else begin
			if (wr_acc && sel_acc[0]) begin
				mon_buf_r <= pwdata[7:0];
			end
			if (wr_acc && sel_acc[1]) begin
				yr_buf_r <= pwdata[7:0];
			end
		end
	end

	// pending flags, cleared by the tick that moves the buffer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mon_pend_r <= 1'b0;
			yr_pend_r <= 1'b0;
		end else begin
			mon_pend_r <= mon_pend_nxt;
			yr_pend_r <= yr_pend_nxt;
		end
	end

	// ----------------------------------------------------------------
	// calendar stages
	// ----------------------------------------------------------------
	// month stage, counting on day carries while enabled
	cmyc_bcd_stage #(
		.MIN_V(MONTH_MIN),
		.MAX_V(MONTH_MAX),
		.RST_V(MONTH_RESET)
	) u_month (
		.clk(pclk),
		.rstn(presetn),
		.tick(tick),
		.carry_in(day_carry && cnt_en),
		.load(mon_pend_r),
		.load_val(mon_buf_r),
		.count_r(mon_q),
		.carry_out(mon_carry)
	);

	// year stage, fed in the same tick by the month overflow
	cmyc_bcd_stage #(
		.MIN_V(YEAR_MIN),
		.MAX_V(YEAR_MAX),
		.RST_V(YEAR_RESET)
	) u_year (
		.clk(pclk),
		.rstn(presetn),
		.tick(tick),
		.carry_in(mon_carry),
		.load(yr_pend_r),
		.load_val(yr_buf_r),
		.count_r(yr_q),
		.carry_out(yr_carry)
	);

	// ----------------------------------------------------------------
	// status outputs
	// ----------------------------------------------------------------
	// leap flag trails the year count by one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			leap_r <= 1'b1;
		end else begin
			leap_r <= cmyc_is_leap(yr_q);
		end
	end

	// year rollover pulse for whatever stage sits above
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			year_wrap_r <= 1'b0;
		end else begin
			year_wrap_r <= yr_carry;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign month_count = mon_q;
	assign year_count = yr_q;
	assign leap_year = leap_r;
	assign year_wrap = year_wrap_r;

	// ----------------------------------------------------------------
	// check helpers
	// ----------------------------------------------------------------
	// ticks seen while a write has been waiting; a new write restarts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mon_wait_r <= 2'h0;
			yr_wait_r <= 2'h0;
		end else begin
			if (!mon_pend_r || (wr_acc && sel_acc[0])) begin
				mon_wait_r <= 2'h0;
			end else if (tick && mon_wait_r != 2'h3) begin
				mon_wait_r <= mon_wait_r + 2'h1;
			end
			if (!yr_pend_r || (wr_acc && sel_acc[1])) begin
				yr_wait_r <= 2'h0;
			end else if (tick && yr_wait_r != 2'h3) begin
				yr_wait_r <= yr_wait_r + 2'h1;
			end
		end
	end

	// marks the first cycle after reset release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_seen_r <= 1'b0;
		end else begin
			rst_seen_r <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_xfer_bound: assert property (@(posedge pclk) disable iff (!presetn)
		(mon_pend_r |-> mon_wait_r < 2'(XFER_MAX_TICKS))
		and (yr_pend_r |-> yr_wait_r < 2'(XFER_MAX_TICKS)))
		else $error("buffered write outlived two calendar ticks");

	a_reset_vals: assert property (@(posedge pclk) disable iff (!presetn)
		!rst_seen_r |-> (mon_q == MONTH_RESET) && (yr_q == YEAR_RESET))
		else $error("counters not at reset values after release");

	a_month_step: assert property (@(posedge pclk) disable iff (!presetn)
		(tick && day_carry && cnt_en && !mon_pend_r && mon_q != MONTH_MAX
		&& mon_q < MONTH_MAX) |=> (mon_q != $past(mon_q)) && !mon_carry)
		else $error("month did not advance on a day carry");

	a_year_step: assert property (@(posedge pclk) disable iff (!presetn)
		(mon_carry && !yr_pend_r) |=> (mon_q == MONTH_MIN)
		&& (yr_q != $past(yr_q)))
		else $error("year did not advance on a month overflow");

	a_leap_flag: assert property (@(posedge pclk) disable iff (!presetn)
		(yr_q == 8'h96 || yr_q == 8'h00) ##1 (yr_q == $past(yr_q))
		|-> leap_r)
		else $error("multiple-of-four year not flagged as leap");

	a_apb_read: assert property (@(posedge pclk) disable iff (!presetn)
		(setup_ph && !pwrite && paddr == ADDR_YEAR)
		|=> pready_r && (prdata_r == {24'h00_0000, $past(yr_q)}))
		else $error("year read did not return the counter");

	a_no_carry_load: assert property (@(posedge pclk) disable iff (!presetn)
		(tick && yr_pend_r) |-> !yr_carry ##1 (yr_q == $past(yr_buf_r)))
		else $error("month carry disturbed a year write");

endmodule

/* verification/testbench.sv */
// self-checking bench for the month and year calendar counters
`timescale 1ns/10ps
module testbench;
	import cmyc_pkg::*;

	// ----------------------------------------------------------------
	// setup
	// ----------------------------------------------------------------
	localparam int DIV = 12; // short tick period keeps the run brief
	typedef struct {
		logic [7:0] m;
		logic [7:0] y;
		logic [7:0] me;
		logic [7:0] ye;
		int we;
	} cmyc_row_s;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic day_carry = 1'b0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] month_count;
	logic [7:0] year_count;
	logic leap_year;
	logic year_wrap;
	int fails = 0;
	int num_checks = 0;
	int cyc = 0;
	int wrap_cnt = 0;
	logic [31:0] rd;
	logic err;
	// written values stay inside the documented bcd ranges
	cmyc_row_s rows[5] = '{
		'{8'h09, 8'h19, 8'h10, 8'h19, 0},
		'{8'h12, 8'h19, 8'h01, 8'h20, 0},
		'{8'h12, 8'h99, 8'h01, 8'h00, 1},
		'{8'h12, 8'h03, 8'h01, 8'h04, 0},
		'{8'h05, 8'h96, 8'h06, 8'h96, 0}};

	cmyc_top #(.RTC_DIV(DIV)) i_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .day_carry(day_carry),
		.month_count(month_count), .year_count(year_count),
		.leap_year(leap_year), .year_wrap(year_wrap));

	// clock, cycle count, hang guard and wrap pulse counter
	always #2 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (year_wrap === 1'b1) begin
			wrap_cnt <= wrap_cnt + 1;
		end
		if (cyc == 20000) begin
			fails = fails + 1;
			close_out();
		end
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk32(string n, logic [31:0] e, logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
		chk32(n, {24'h0, e}, {24'h0, g});
	endtask

	// one apb transfer; holds the request until pready is sampled high
	task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			n++;
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic put(logic [7:0] a, logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
		chk8("pslverr", 8'h00, {7'h0, err});
	endtask

	// wait until both buffered writes reached the counters
	task automatic land();
		int t0;
		int n;
		t0 = cyc;
		n = 0;
		rd = 32'h3;
		while (rd[1:0] !== 2'b00 && n < 4 * DIV) begin
			apb(1'b0, ADDR_STAT, 32'h0);
			n++;
		end
		chk8("landing", 8'h01, {7'h0, (cyc - t0) <= 2 * DIV + 6});
	endtask

	function automatic logic leap_of(logic [7:0] y);
		leap_of = ((int'(y[7:4]) * 10 + int'(y[3:0])) % 4) == 0;
	endfunction

	task automatic chk_counts(logic [7:0] m, logic [7:0] y);
		@(negedge pclk);
		chk8("month", m, month_count);
		chk8("year", y, year_count);
		chk8("leap", {7'h0, leap_of(y)}, {7'h0, leap_year});
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		chk_counts(8'h01, 8'h00);
		$display("test reset done");
		foreach (rows[i]) begin
			put(ADDR_MONTH, rows[i].m);
			put(ADDR_YEAR, rows[i].y);
			land();
			wrap_cnt = 0;
			day_carry <= 1'b1;
			repeat (DIV) @(posedge pclk);
			day_carry <= 1'b0;
			repeat (3) @(posedge pclk);
			chk_counts(rows[i].me, rows[i].ye);
			chk8("wraps", 8'(rows[i].we), 8'(wrap_cnt));
			apb(1'b0, ADDR_MONTH, 32'h0);
			chk32("month_rd", {24'h0, rows[i].me}, rd);
			apb(1'b0, ADDR_YEAR, 32'h0);
			chk32("year_rd", {24'h0, rows[i].ye}, rd);
			$display("test row %0d done", i);
		end
		// a month write meets a day carry: carry dropped, no ripple
		put(ADDR_MONTH, 8'h12);
		put(ADDR_YEAR, 8'h40);
		land();
		day_carry <= 1'b1;
		put(ADDR_MONTH, 8'h05);
		land();
		day_carry <= 1'b0;
		chk_counts(8'h05, 8'h40);
		$display("test month write wins done");
		// a year write meets the month carry
		put(ADDR_MONTH, 8'h12);
		land();
		day_carry <= 1'b1;
		put(ADDR_YEAR, 8'h77);
		land();
		day_carry <= 1'b0;
		chk_counts(8'h01, 8'h77);
		$display("test year write wins done");
		// counting disabled ignores the day carry
		put(ADDR_CTRL, 8'h00);
		put(ADDR_MONTH, 8'h03);
		land();
		day_carry <= 1'b1;
		repeat (2 * DIV) @(posedge pclk);
		day_carry <= 1'b0;
		chk_counts(8'h03, 8'h77);
		put(ADDR_CTRL, 8'h01);
		$display("test count disable done");
		// unmapped address errors and leaves the counters alone
		apb(1'b1, 8'h10, 32'h0000_0009);
		chk8("slverr_wr", 8'h01, {7'h0, err});
		apb(1'b0, 8'h10, 32'h0);
		chk8("slverr_rd", 8'h01, {7'h0, err});
		chk32("unmapped_rd", 32'h0, rd);
		apb(1'b0, ADDR_MONTH, 32'h0);
		chk32("month_kept", 32'h0000_0003, rd);
		$display("test unmapped done");
		// second reset in mid run
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		chk_counts(8'h01, 8'h00);
		presetn <= 1'b1;
		$display("test second reset done");
		close_out();
	end
endmodule
